// [rtl/epscp_pkg.sv]
// Package with opcodes, defaults and timing constants of the command port.
package epscp_pkg;
  // ****************************************************************
  // Opcodes
  // ****************************************************************
  localparam logic [7:0] OP_PANEL_CONFIG   = 8'h00;
  localparam logic [7:0] OP_SUPPLY_CONFIG  = 8'h01;
  localparam logic [7:0] OP_SUPPLY_OFF     = 8'h02;
  localparam logic [7:0] OP_SUPPLY_ON      = 8'h04;
  localparam logic [7:0] OP_BOOSTER_SS     = 8'h06;
  localparam logic [7:0] OP_DEEP_SLEEP     = 8'h07;
  localparam logic [7:0] OP_FRAME_BEGIN    = 8'h10;
  localparam logic [7:0] OP_FRAME_END      = 8'h11;
  localparam logic [7:0] OP_REFRESH        = 8'h12;
  localparam logic [7:0] OP_AUTO_SEQ       = 8'h17;
  localparam logic [7:0] OP_FRAME_RATE     = 8'h30;
  localparam logic [7:0] OP_TEMP_READ      = 8'h40;
  localparam logic [7:0] OP_TEMP_SELECT    = 8'h41;
  localparam logic [7:0] OP_TEMP_WRITE     = 8'h42;
  localparam logic [7:0] SLEEP_KEY         = 8'hA5;
  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] PANEL1_RST        = 8'h0F;
  localparam logic [7:0] PANEL2_RST        = 8'h09;
  localparam logic [7:0] SUPPLY1_RST       = 8'h07;
  localparam logic [5:0] PH_ON_RST         = 6'h02;
  localparam logic [5:0] PH_OFF_RST        = 6'h07;
  localparam logic [2:0] FRAME_RATE_RST    = 3'h2;
  localparam int         PANEL_SOFT_RST_BIT = 0;
  localparam int         PANEL_TABLE_BIT    = 7;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ        = 25;
  localparam int I2C_KHZ        = 100;
  localparam int I2C_QTR_CYC    = (CLK_MHZ * 1000) / (I2C_KHZ * 4);
  localparam int OP_TIME_US     = 100;
  localparam int OP_CYC         = OP_TIME_US * CLK_MHZ;
  localparam logic [6:0] SENSOR_ADDR = 7'h48;
  typedef enum logic [1:0] {EPSCP_RX_IDLE, EPSCP_RX_BITS} epscp_rx_t;
endpackage : epscp_pkg

// [rtl/epscp_fifo.sv]
// Synchronous FIFO for image data bytes.
`timescale 1ns/10ps
module epscp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  wire              full  = (wr_q[AW] != rd_q[AW]) &&
                            (wr_q[AW-1:0] == rd_q[AW-1:0]);
  wire              empty = (wr_q == rd_q);
  wire              push  = in_valid_i && !full;
  wire              pop   = out_ready_i && !empty;
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem_q[rd_q[AW-1:0]];
  always_ff @(posedge sys_clk_i)
  begin
    if (push)
    begin
      mem_q[wr_q[AW-1:0]] <= in_data_i;
    end
  end
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      wr_q <= push ? wr_q + 1'b1 : wr_q;
      rd_q <= pop ? rd_q + 1'b1 : rd_q;
    end
  end
endmodule : epscp_fifo

// [rtl/epscp_port.sv]
// Serial command port: byte receiver, decoder, settings, I2C master.
`timescale 1ns/10ps
module epscp_port
  import epscp_pkg::*;
#(
  parameter int OP_CYCLES = OP_CYC
) (
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic       reset_n_i,
  // Host serial port
  input  wire logic       chip_select_low_i,
  input  wire logic       sclk_i,
  input  wire logic       cmd_data_pin_i,
  input  wire logic       sdata_i,
  output logic            sdata_o,
  output logic            sdata_oe_n_o,
  // Sensor I2C pins
  output logic            sensor_i2c_clock_pin_o,
  input  wire logic       sensor_i2c_data_pin_i,
  output logic            sensor_i2c_data_pin_o,
  output logic            sensor_i2c_data_oe_n_o,
  // Image data stream
  output logic [7:0]      image_data_o,
  output logic            image_valid_o,
  input  wire logic       image_ready_i,
  // Status and settings
  output logic            busy_n_o,
  output logic            deep_sleep_o,
  output logic            supply_on_o,
  output logic [7:0]      panel_cfg1_o,
  output logic [7:0]      panel_cfg2_o,
  output logic            table_source_sel_o,
  output logic [3:0]      supply_mode_o,
  output logic [1:0]      gate_voltage_level_o,
  output logic [27:0]     source_levels_o,
  output logic [35:0]     booster_phases_o,
  output logic [2:0]      frame_rate_sel_o,
  output logic [7:0]      auto_code_o,
  output logic            temp_select_o,
  output logic [4:0]      temp_offset_o
);
  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [4:0] s1_q;
  logic [4:0] s2_q;
  logic       sclk_d1_q;
  always_ff @(posedge sys_clk_i)
  begin
    s1_q      <= {reset_n_i, chip_select_low_i, sclk_i, cmd_data_pin_i,
                  sdata_i};
    s2_q      <= s1_q;
    sclk_d1_q <= s2_q[2];
  end
  wire rst_all  = rst_i || !s2_q[4];
  wire cs_act   = !s2_q[3];
  wire sck_rise = s2_q[2] && !sclk_d1_q;
  wire sck_fall = !s2_q[2] && sclk_d1_q;
  wire dc_lvl   = s2_q[1];
  wire din      = s2_q[0];
  // ****************************************************************
  // Byte receiver and read shifter
  // ****************************************************************
  logic [2:0] bit_q;
  logic [7:0] sh_q;
  logic       byte_stb_q;
  logic [7:0] byte_q;
  logic       byte_dc_q;
  logic       rd_mode_q;
  logic [7:0] rd_sh_q;
  logic [1:0] rd_idx_q;
  logic [2:0] rd_bit_q;
  logic       dflag_q;
  logic [9:0] temp_q;
  // Byte that follows the one now being shifted out.
  wire  [7:0] rd_next = (rd_idx_q == 2'd0) ? {dflag_q, 7'h00} :
                        (rd_idx_q == 2'd1) ? {temp_q[1:0], 6'h00} :
                        8'h00;
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_all || !cs_act)
    begin
      bit_q      <= 3'd0;
      sh_q       <= 8'h00;
      byte_stb_q <= 1'b0;
      byte_q     <= 8'h00;
      byte_dc_q  <= 1'b0;
    end
    else
    begin
      byte_stb_q <= 1'b0;
      // Bits are only taken while the device is not driving the line.
      if (sck_rise && !rd_mode_q)
      begin
        sh_q  <= {sh_q[6:0], din};
        bit_q <= bit_q + 3'd1;
        if (bit_q == 3'd7)
        begin
          byte_stb_q <= 1'b1;
          byte_q     <= {sh_q[6:0], din};
          byte_dc_q  <= dc_lvl;
        end
      end
    end
  end
  // ****************************************************************
  // Decoder state
  // ****************************************************************
  logic [7:0] op_q;
  logic [2:0] pidx_q;
  logic       frame_q;
  wire  is_cmd  = byte_stb_q && !byte_dc_q;
  wire  is_par  = byte_stb_q && byte_dc_q;
  wire  p0 = is_par && pidx_q == 3'd0;
  wire  p1 = is_par && pidx_q == 3'd1;
  wire  p2 = is_par && pidx_q == 3'd2;
  wire  p3 = is_par && pidx_q == 3'd3;
  wire  p4 = is_par && pidx_q == 3'd4;
  wire  p5 = is_par && pidx_q == 3'd5;
  wire  soft_rst = (op_q == OP_PANEL_CONFIG) && p0 &&
                   !byte_q[PANEL_SOFT_RST_BIT];
  wire  wants_read = is_cmd && (byte_q == OP_FRAME_END ||
                                byte_q == OP_TEMP_READ);
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_all || soft_rst)
    begin
      op_q    <= 8'hFF;
      pidx_q  <= 3'd0;
      frame_q <= 1'b0;
    end
    else if (is_cmd)
    begin
      op_q    <= byte_q;
      pidx_q  <= 3'd0;
      frame_q <= (byte_q == OP_FRAME_BEGIN);
    end
    else if (is_par)
    begin
      pidx_q  <= (pidx_q == 3'd7) ? pidx_q : pidx_q + 3'd1;
    end
  end
  // ****************************************************************
  // Read phase: drive on falling edge, host samples on rising
  // ****************************************************************
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_all || !cs_act)
    begin
      rd_mode_q    <= 1'b0;
      rd_sh_q      <= 8'h00;
      rd_idx_q     <= 2'd0;
      rd_bit_q     <= 3'd0;
      sdata_o      <= 1'b0;
      sdata_oe_n_o <= 1'b1;
    end
    else if (wants_read)
    begin
      rd_mode_q <= 1'b1;
      rd_bit_q  <= 3'd0;
      rd_idx_q  <= (byte_q == OP_TEMP_READ) ? 2'd1 : 2'd0;
      // The flag is set by this same opcode, so it reads as one.
      rd_sh_q   <= (byte_q == OP_TEMP_READ) ? temp_q[9:2]
                                            : {1'b1, 7'h00};
    end
    else if (rd_mode_q && sck_fall)
    begin
      sdata_oe_n_o <= 1'b0;
      sdata_o      <= rd_sh_q[7];
      rd_sh_q      <= {rd_sh_q[6:0], 1'b0};
      rd_bit_q     <= rd_bit_q + 3'd1;
      if (rd_bit_q == 3'd7)
      begin
        rd_idx_q <= (rd_idx_q == 2'd1) ? 2'd2 : rd_idx_q;
        rd_sh_q  <= rd_next;
      end
    end
  end
  // ****************************************************************
  // Settings written through opcodes
  // ****************************************************************
  logic [7:0] sup_q [6];
  logic [5:0] ph_q  [6];
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_all || soft_rst)
    begin
      panel_cfg1_o <= PANEL1_RST;
      panel_cfg2_o <= PANEL2_RST;
      frame_rate_sel_o <= FRAME_RATE_RST;
      auto_code_o   <= 8'h00;
      temp_select_o <= 1'b0;
      temp_offset_o <= 5'h00;
    end
    else
    begin
      if (op_q == OP_PANEL_CONFIG && p0)
        panel_cfg1_o <= byte_q;
      if (op_q == OP_PANEL_CONFIG && p1)
        panel_cfg2_o <= byte_q;
      if (op_q == OP_FRAME_RATE && p0)
        frame_rate_sel_o <= byte_q[2:0];
      if (op_q == OP_AUTO_SEQ && p0)
        auto_code_o <= byte_q;
      if (op_q == OP_TEMP_SELECT && p0)
      begin
        temp_select_o <= byte_q[7];
        temp_offset_o <= byte_q[4:0];
      end
    end
  end
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++)
    begin : g_six
      always_ff @(posedge sys_clk_i)
      begin
        if (rst_all || soft_rst)
        begin
          sup_q[gi] <= (gi == 0) ? SUPPLY1_RST : 8'h00;
          ph_q[gi]  <= (gi % 2 == 1) ? PH_OFF_RST : PH_ON_RST;
        end
        else if (is_par && pidx_q == 3'(gi))
        begin
          if (op_q == OP_SUPPLY_CONFIG)
            sup_q[gi] <= byte_q;
          if (op_q == OP_BOOSTER_SS)
            ph_q[gi] <= byte_q[5:0];
        end
      end
      assign booster_phases_o[gi*6 +: 6] = ph_q[gi];
    end
  endgenerate
  assign supply_mode_o        = sup_q[0][3:0];
  assign gate_voltage_level_o = sup_q[1][1:0];
  assign source_levels_o      = {sup_q[5][6:0], sup_q[4][6:0],
                                 sup_q[3][6:0], sup_q[2][6:0]};
  assign table_source_sel_o   = panel_cfg2_o[PANEL_TABLE_BIT];
  // ****************************************************************
  // Power, sleep, refresh and busy
  // ****************************************************************
  logic [31:0] busy_cnt_q;
  logic        pwr_opt_q;
  logic        vcom_opt_q;
  wire start_op = is_cmd && (byte_q == OP_SUPPLY_ON ||
                  byte_q == OP_SUPPLY_OFF || byte_q == OP_REFRESH);
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_all || soft_rst)
    begin
      supply_on_o  <= 1'b0;
      deep_sleep_o <= 1'b0;
      pwr_opt_q    <= 1'b0;
      vcom_opt_q   <= 1'b0;
      busy_cnt_q   <= '0;
      busy_n_o     <= 1'b1;
      dflag_q      <= 1'b0;
    end
    else
    begin
      if (is_cmd && byte_q == OP_SUPPLY_ON)
        supply_on_o <= 1'b1;
      if (is_cmd && byte_q == OP_SUPPLY_OFF)
        supply_on_o <= 1'b0;
      if (op_q == OP_SUPPLY_OFF && p0)
        pwr_opt_q <= byte_q[0];
      if (op_q == OP_REFRESH && p0)
        vcom_opt_q <= byte_q[0];
      if (op_q == OP_DEEP_SLEEP && p0 && byte_q == SLEEP_KEY)
        deep_sleep_o <= 1'b1;
      if (is_cmd && byte_q == OP_FRAME_END)
        dflag_q <= 1'b1;
      else if (is_cmd && byte_q == OP_FRAME_BEGIN)
        dflag_q <= 1'b0;
      if (start_op)
      begin
        busy_cnt_q <= 32'(OP_CYCLES);
        busy_n_o   <= 1'b0;
      end
      else if (busy_cnt_q != '0)
      begin
        busy_cnt_q <= busy_cnt_q - 32'd1;
        busy_n_o   <= (busy_cnt_q == 32'd1);
      end
    end
  end
  // ****************************************************************
  // Image data path
  // ****************************************************************
  logic fifo_in_ready;
  epscp_fifo #(.WIDTH(8), .DEPTH(16)) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .rst_i       (rst_all),
    .in_data_i   (byte_q),
    .in_valid_i  (frame_q && is_par),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (image_data_o),
    .out_valid_o (image_valid_o),
    .out_ready_i (image_ready_i)
  );
  // ****************************************************************
  // Sensor I2C master: write 3 bytes, or read 2 bytes
  // ****************************************************************
  logic [7:0] tsw_q [3];
  logic [2:0] i2c_byte_q;
  logic [3:0] i2c_bit_q;
  logic [1:0] i2c_ph_q;
  logic [9:0] i2c_div_q;
  logic       i2c_act_q;
  logic       i2c_rd_q;
  logic [8:0] i2c_sh_q;
  logic [15:0] i2c_rx_q;
  wire        i2c_tick = (i2c_div_q == 10'(I2C_QTR_CYC - 1));
  wire [2:0]  i2c_last = i2c_rd_q ? 3'd2 : 3'd3;
  wire [7:0]  i2c_tx   = (i2c_byte_q == 3'd0) ? {SENSOR_ADDR, i2c_rd_q} :
                         i2c_rd_q ? 8'hFF : tsw_q[2'(i2c_byte_q - 3'd1)];
  wire        ack_bit  = i2c_rd_q && i2c_byte_q == 3'd1;
  wire        i2c_go_w = op_q == OP_TEMP_WRITE && p2;
  wire        i2c_go_r = is_cmd && byte_q == OP_TEMP_READ;
  // Sensor data line passes its own two-stage synchroniser.
  logic i2c_s1_q;
  logic i2c_sda_s;
  always_ff @(posedge sys_clk_i)
  begin
    i2c_s1_q  <= sensor_i2c_data_pin_i;
    i2c_sda_s <= i2c_s1_q;
  end
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_all)
    begin
      tsw_q[0] <= 8'h00;
      tsw_q[1] <= 8'h00;
      tsw_q[2] <= 8'h00;
      i2c_act_q <= 1'b0;
      i2c_rd_q  <= 1'b0;
      i2c_div_q <= '0;
      i2c_ph_q  <= '0;
      i2c_bit_q <= '0;
      i2c_byte_q <= '0;
      i2c_sh_q  <= '1;
      i2c_rx_q  <= '0;
      temp_q    <= '0;
      sensor_i2c_clock_pin_o <= 1'b1;
      sensor_i2c_data_pin_o  <= 1'b0;
      sensor_i2c_data_oe_n_o <= 1'b1;
    end
    else if (!i2c_act_q)
    begin
      if (op_q == OP_TEMP_WRITE && is_par && pidx_q < 3'd3)
        tsw_q[2'(pidx_q)] <= byte_q;
      if (i2c_go_w || i2c_go_r)
      begin
        i2c_act_q <= 1'b1;
        i2c_rd_q  <= i2c_go_r;
        i2c_byte_q <= 3'd0;
        i2c_bit_q <= 4'd0;
        i2c_ph_q  <= 2'd0;
        sensor_i2c_data_oe_n_o <= 1'b0;                      // Start.
      end
    end
    else
    begin
      i2c_div_q <= i2c_tick ? '0 : i2c_div_q + 10'd1;
      if (i2c_tick)
      begin
        i2c_ph_q <= i2c_ph_q + 2'd1;
        case (i2c_ph_q)
          2'd0: sensor_i2c_clock_pin_o <= 1'b0;
          2'd1:
          begin
            // Data changes while clock is low; the ninth bit is ack.
            if (i2c_byte_q > i2c_last)
              sensor_i2c_data_oe_n_o <= 1'b0;
            else if (i2c_bit_q < 4'd8)
              sensor_i2c_data_oe_n_o <= i2c_rd_q && i2c_byte_q != 3'd0
                                        ? 1'b1 : i2c_tx[3'd7 - i2c_bit_q[2:0]];
            else
              sensor_i2c_data_oe_n_o <= !ack_bit;
          end
          2'd2:
          begin
            sensor_i2c_clock_pin_o <= 1'b1;
            if (i2c_rd_q && i2c_byte_q != 3'd0 && i2c_bit_q < 4'd8)
              i2c_rx_q <= {i2c_rx_q[14:0], i2c_sda_s};
          end
          default:
          begin
            if (i2c_byte_q > i2c_last)
            begin
              sensor_i2c_data_oe_n_o <= 1'b1;                // Stop.
              i2c_act_q <= 1'b0;
              if (i2c_rd_q)
                temp_q <= i2c_rx_q[15:6];
            end
            else if (i2c_bit_q == 4'd8)
            begin
              i2c_bit_q  <= 4'd0;
              i2c_byte_q <= i2c_byte_q + 3'd1;
            end
            else
              i2c_bit_q <= i2c_bit_q + 4'd1;
          end
        endcase
      end
    end
  end
  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_temp_op;
    cs_act && is_cmd && byte_q == OP_TEMP_READ;
  endsequence
  sequence s_i2c_begin;
    (i2c_go_w || i2c_go_r) && !i2c_act_q;
  endsequence
  sequence s_i2c_start_cond;
    i2c_act_q && !sensor_i2c_data_oe_n_o && sensor_i2c_clock_pin_o;
  endsequence
  a_sleep_key: assert property (
    @(posedge sys_clk_i) disable iff (rst_all)
    (op_q == OP_DEEP_SLEEP && p0 && byte_q != SLEEP_KEY && !deep_sleep_o)
    |=> !deep_sleep_o) else $error("sleep without key");
  a_sleep_enter: assert property (
    @(posedge sys_clk_i) disable iff (rst_all)
    (op_q == OP_DEEP_SLEEP && p0 && byte_q == SLEEP_KEY)
    |=> deep_sleep_o) else $error("key did not enter sleep");
  a_busy_start: assert property (
    @(posedge sys_clk_i) disable iff (rst_all)
    start_op && !soft_rst |=> !busy_n_o) else $error("busy not low");
  a_no_drive_wr: assert property (
    @(posedge sys_clk_i) disable iff (rst_all)
    !rd_mode_q |-> sdata_oe_n_o) else $error("drive outside read");
  a_soft_reset: assert property (
    @(posedge sys_clk_i) disable iff (rst_all)
    soft_rst |=> panel_cfg1_o == PANEL1_RST && !supply_on_o)
    else $error("soft reset failed");
  a_temp_load: assert property (
    @(posedge sys_clk_i) disable iff (rst_all)
    s_temp_op |=> rd_mode_q && rd_sh_q == $past(temp_q[9:2]))
    else $error("temperature byte not loaded");
  a_i2c_start: assert property (
    @(posedge sys_clk_i) disable iff (rst_all)
    s_i2c_begin |=> s_i2c_start_cond) else $error("no start condition");
  a_frame_push: assert property (
    @(posedge sys_clk_i) disable iff (rst_all)
    frame_q && is_par && fifo_in_ready |=> image_valid_o)
    else $error("image byte not stored");
endmodule : epscp_port

// [dv/epscp_host.sv]
// Host controller model driving the serial command port.
`timescale 1ns/10ps
module epscp_host #(
  parameter int HALF = 6
) (
  // Clock
  input  wire logic sys_clk_i,
  // Serial pins
  output logic      cs_n_o,
  output logic      sclk_o,
  output logic      dc_o,
  output logic      sda_o,
  output logic      sda_en_o,
  input  wire logic sda_i
);
  initial
  begin
    cs_n_o   = 1'b1;
    sclk_o   = 1'b0;
    dc_o     = 1'b0;
    sda_o    = 1'b0;
    sda_en_o = 1'b0;
  end

  // Sends a byte MSB first, then leaves the clock high as a turnaround gap.
  task automatic put(input logic [7:0] b, input logic dc);
    cs_n_o   = 1'b0;
    dc_o     = dc;
    sda_en_o = 1'b1;
    for (int i = 7; i >= 0; i--)
    begin
      sclk_o = 1'b0;
      sda_o  = b[i];
      repeat (HALF) @(negedge sys_clk_i);
      sclk_o = 1'b1;
      repeat (HALF) @(negedge sys_clk_i);
    end
    sda_en_o = 1'b0;
    repeat (2 * HALF) @(negedge sys_clk_i);
  endtask : put

  // Reads a byte; the device drives on falling clock edges.
  task automatic get(output logic [7:0] b);
    dc_o     = 1'b1;
    sda_en_o = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      sclk_o = 1'b0;
      repeat (HALF) @(negedge sys_clk_i);
      sclk_o = 1'b1;
      b[i]   = sda_i;
      repeat (HALF) @(negedge sys_clk_i);
    end
  endtask : get

  task automatic stop;
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    repeat (4 * HALF) @(negedge sys_clk_i);
  endtask : stop
endmodule : epscp_host

// [dv/epscp_port_tb.sv]
// Self-checking bench for the serial command port.
`timescale 1ns/10ps
module epscp_port_tb;
  import epscp_pkg::*;
  localparam int OPC = 40;
  logic        sys_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        reset_n_i = 1'b1;
  logic        image_ready_i = 1'b0;
  logic        flip = 1'b0;
  logic        cs_n, sclk, dc, h_sda, h_en;
  logic        sdata_o, sdata_oe_n_o, i2c_clk, i2c_oe_n, i2c_dout;
  logic [7:0]  image_data_o, panel_cfg1_o, panel_cfg2_o, auto_code_o;
  logic        image_valid_o, busy_n_o, deep_sleep_o, supply_on_o;
  logic        table_source_sel_o, temp_select_o;
  logic [3:0]  supply_mode_o;
  logic [1:0]  gate_voltage_level_o;
  logic [27:0] source_levels_o;
  logic [35:0] booster_phases_o;
  logic [2:0]  frame_rate_sel_o;
  logic [4:0]  temp_offset_o;
  int          mismatches = 0;
  int          samples_checked = 0;
  // Released lines show a changing pattern; the sensor line has a pull-up.
  wire         sda_w = !sdata_oe_n_o ? sdata_o : (h_en ? h_sda : flip);
  wire         i2c_din = i2c_oe_n;

  always #20 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) flip <= ~flip;

  epscp_host host_u (.sys_clk_i, .cs_n_o(cs_n), .sclk_o(sclk), .dc_o(dc),
    .sda_o(h_sda), .sda_en_o(h_en), .sda_i(sda_w));

  epscp_port #(.OP_CYCLES(OPC)) dut_u (.sys_clk_i, .rst_i, .reset_n_i,
    .chip_select_low_i(cs_n), .sclk_i(sclk), .cmd_data_pin_i(dc),
    .sdata_i(sda_w), .sdata_o, .sdata_oe_n_o,
    .sensor_i2c_clock_pin_o(i2c_clk), .sensor_i2c_data_pin_i(i2c_din),
    .sensor_i2c_data_pin_o(i2c_dout), .sensor_i2c_data_oe_n_o(i2c_oe_n),
    .image_data_o, .image_valid_o, .image_ready_i, .busy_n_o,
    .deep_sleep_o, .supply_on_o, .panel_cfg1_o, .panel_cfg2_o,
    .table_source_sel_o, .supply_mode_o, .gate_voltage_level_o,
    .source_levels_o, .booster_phases_o, .frame_rate_sel_o, .auto_code_o,
    .temp_select_o, .temp_offset_o);

  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic close_out;
    $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out

  task automatic cmd(input logic [7:0] op, input logic [7:0] p[$]);
    host_u.put(op, 1'b0);
    foreach (p[i])
      host_u.put(p[i], 1'b1);
    host_u.stop();
    chk(sdata_oe_n_o, 1'b1);
  endtask : cmd

  task automatic busy_is(input logic lvl);
    for (int n = 0; busy_n_o !== lvl; n++)
    begin
      if (n > 3 * OPC)
      begin
        mismatches++;
        close_out();
      end
      @(negedge sys_clk_i);
    end
  endtask : busy_is

  task automatic defaults;
    chk(panel_cfg1_o, PANEL1_RST);
    chk(panel_cfg2_o, PANEL2_RST);
    chk(table_source_sel_o, 1'b0);
    chk(supply_mode_o, SUPPLY1_RST[3:0]);
    chk(gate_voltage_level_o, 2'h0);
    chk(source_levels_o, 28'h0);
    chk(booster_phases_o, {3{PH_OFF_RST, PH_ON_RST}});
    chk(frame_rate_sel_o, FRAME_RATE_RST);
    chk(supply_on_o, 1'b0);
    chk(deep_sleep_o, 1'b0);
    chk(busy_n_o, 1'b1);
  endtask : defaults

  // ****************************************************************
  // Stimulus
  // ****************************************************************
  initial
  begin
    logic [7:0] rd;
    int         edges;
    logic       clk_was;
    logic [35:0] wire_bits;
    repeat (8) @(negedge sys_clk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge sys_clk_i);
    defaults();
    cmd(8'h00, {8'hF3, 8'h8A});
    chk({panel_cfg1_o, panel_cfg2_o}, 16'hF38A);
    chk(table_source_sel_o, 1'b1);
    cmd(8'h01, {8'h0A, 8'h03, 8'h91, 8'h22, 8'h33, 8'h44});
    chk(supply_mode_o, 4'hA);
    chk(gate_voltage_level_o, 2'h3);
    chk(source_levels_o, {7'h44, 7'h33, 7'h22, 7'h11});
    cmd(8'h06, {8'hC1, 8'h02, 8'h03, 8'h3F, 8'h05, 8'h06});
    chk(booster_phases_o, {6'h06, 6'h05, 6'h3F, 6'h03, 6'h02, 6'h01});
    cmd(8'h30, {8'hFD});
    chk(frame_rate_sel_o, 3'h5);
    cmd(8'h17, {8'h3C});
    chk(auto_code_o, 8'h3C);
    cmd(8'h41, {8'h93});
    chk({temp_select_o, temp_offset_o}, 6'h33);
    cmd(8'h17, {8'h04});
    chk(supply_on_o, 1'b0);
    chk(auto_code_o, 8'h04);
    host_u.put(8'h04, 1'b0);
    chk({supply_on_o, busy_n_o}, 2'h2);
    host_u.stop();
    busy_is(1'b1);
    cmd(8'h02, {8'h01});
    chk(supply_on_o, 1'b0);
    host_u.put(8'h12, 1'b0);
    chk(busy_n_o, 1'b0);
    host_u.put(8'h01, 1'b1);
    host_u.stop();
    busy_is(1'b1);
    cmd(8'h07, {8'h5A});
    chk(deep_sleep_o, 1'b0);
    cmd(8'h07, {8'hA5});
    chk(deep_sleep_o, 1'b1);
    reset_n_i = 1'b0;
    repeat (4) @(negedge sys_clk_i);
    reset_n_i = 1'b1;
    repeat (6) @(negedge sys_clk_i);
    defaults();
    cmd(8'h30, {8'h04});
    cmd(8'h00, {8'hFE, 8'h8A});
    defaults();
    host_u.put(8'h10, 1'b0);
    for (int i = 0; i < 18; i++)
      host_u.put(8'(8'h30 + i), 1'b1);
    host_u.stop();
    image_ready_i = 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      chk({image_valid_o, image_data_o}, 9'(9'h130 + i));
      @(negedge sys_clk_i);
    end
    chk(image_valid_o, 1'b0);
    image_ready_i = 1'b0;
    host_u.put(8'h11, 1'b0);
    chk(sdata_oe_n_o, 1'b1);
    host_u.get(rd);
    chk(rd[7], 1'b1);
    chk(sdata_oe_n_o, 1'b0);
    host_u.stop();
    chk(sdata_oe_n_o, 1'b1);
    // First read returns the reset value and starts a sensor read.
    host_u.put(8'h40, 1'b0);
    host_u.get(rd);
    chk(rd, 8'h00);
    host_u.get(rd);
    chk(rd, 8'h00);
    host_u.stop();
    repeat (8000) @(negedge sys_clk_i);
    cmd(8'h42, {8'h11, 8'h22, 8'h33});
    edges = 0;
    wire_bits = '0;
    for (int n = 0; n < 10000; n++)
    begin
      clk_was = i2c_clk;
      @(negedge sys_clk_i);
      if (!clk_was && i2c_clk)
      begin
        if (edges < 36)
          wire_bits = {wire_bits[34:0], i2c_din};
        edges++;
      end
    end
    chk(edges, 37);
    chk(wire_bits, {SENSOR_ADDR, 1'b0, 1'b1, 8'h11, 1'b1,
                    8'h22, 1'b1, 8'h33, 1'b1});
    // The released sensor line reads as all ones through the pull-up.
    host_u.put(8'h40, 1'b0);
    host_u.get(rd);
    chk(rd, 8'hFF);
    host_u.get(rd);
    chk(rd, 8'hC0);
    host_u.stop();
    close_out();
  end
endmodule : epscp_port_tb
